//--- pkg/nvc_pkg.sv
// nvc_pkg: constants for the nonvolatile sram command controller
package nvc_pkg;
  // ****************************************************************
  // geometry
  // ****************************************************************
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int CLK_MHZ = 40;
  // ****************************************************************
  // command sequence addresses
  // ****************************************************************
  localparam logic [14:0] SEQ_A1       = 15'h0E38;
  localparam logic [14:0] SEQ_A2       = 15'h31C7;
  localparam logic [14:0] SEQ_A3       = 15'h03E0;
  localparam logic [14:0] SEQ_A4       = 15'h3C1F;
  localparam logic [14:0] SEQ_A5       = 15'h303F;
  localparam logic [14:0] CMD_SAVE     = 15'h0FC0;
  localparam logic [14:0] CMD_RESTORE  = 15'h0C63;
  localparam logic [14:0] CMD_SAVE_OFF = 15'h03F8;
  localparam logic [14:0] CMD_SAVE_ON  = 15'h07F0;
  // ****************************************************************
  // command codes
  // ****************************************************************
  localparam logic [1:0] OP_SAVE     = 2'h0;
  localparam logic [1:0] OP_RESTORE  = 2'h1;
  localparam logic [1:0] OP_SAVE_OFF = 2'h2;
  localparam logic [1:0] OP_SAVE_ON  = 2'h3;
  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int PH_CYC = 2;   // cycles per bus phase (50 ns)
  localparam int RESTORE_TIME_US = 50;
  localparam int COMMAND_PROCESSING_TIME_US = 70;
  localparam int HW_SAVE_DISABLE_TIME_US = 70;
  localparam int SAVE_REQUEST_PULSE_MIN_NS = 15;
  localparam int SAVE_REQ_CYC =
    (SAVE_REQUEST_PULSE_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int RESTORE_CYC = RESTORE_TIME_US * CLK_MHZ;
  localparam int CMD_PROC_CYC = COMMAND_PROCESSING_TIME_US * CLK_MHZ;
  localparam int HW_DIS_CYC = HW_SAVE_DISABLE_TIME_US * CLK_MHZ;
endpackage

//--- pkg/nvc_bus_if.sv
// nvc_bus_if: cycle request between the sequencer and the pin engine
`timescale 1ns/100ps
`default_nettype none
interface nvc_bus_if;
  logic        start;
  logic        write;
  logic [14:0] addr;
  logic [7:0]  wdata;
  logic        done;
  logic [7:0]  rdata;
  logic        idle;
  modport seq (output start, write, addr, wdata,
               input done, rdata, idle);
  modport eng (input start, write, addr, wdata,
               output done, rdata, idle);
endinterface
`default_nettype wire

//--- hdl/nvc_cycle.sv
// nvc_cycle: one select-controlled bus cycle on the memory pins
`timescale 1ns/100ps
`default_nettype none
module nvc_cycle (
  input  wire logic  mclk,
  input  wire logic  reset,
  nvc_bus_if.eng     bus,
  output logic       sel_n,
  output logic       wr_n,
  output logic       oe_n,
  output logic [14:0] addr,
  output logic [7:0] dq_o,
  output logic       dq_oe,
  input  wire logic [7:0] dq_i
);
  logic [7:0] dq_s1;
  logic [7:0] dq_s2;
  logic [2:0] cnt;
  logic       busy;
  logic       wr;
  // select held low for two phases; data sampled at end
  wire        last = busy && (cnt == 3'(2 * nvc_pkg::PH_CYC - 1));
  assign bus.idle = !busy;
  always_ff @(posedge mclk) begin
    dq_s1 <= dq_i;
    dq_s2 <= dq_s1;
  end
  always_ff @(posedge mclk) begin
    if (reset) begin
      busy <= 1'b0; cnt <= 3'h0; wr <= 1'b0; bus.done <= 1'b0;
      sel_n <= 1'b1; wr_n <= 1'b1; oe_n <= 1'b1; addr <= 15'h0000;
      dq_o <= 8'h00; dq_oe <= 1'b0; bus.rdata <= 8'h00;
    end else begin
      bus.done <= last;
      if (bus.start && !busy) begin
        busy <= 1'b1; cnt <= 3'h0; wr <= bus.write;
        addr <= bus.addr; dq_o <= bus.wdata;
        sel_n <= 1'b0;
        wr_n <= !bus.write;
        oe_n <= bus.write;
        dq_oe <= bus.write;
      end else if (last) begin
        busy <= 1'b0;
        if (!wr) bus.rdata <= dq_s2;
        sel_n <= 1'b1; wr_n <= 1'b1; oe_n <= 1'b1; dq_oe <= 1'b0;
      end else if (busy) begin
        cnt <= cnt + 3'h1;
      end
    end
  end
endmodule
`default_nettype wire

//--- hdl/nvc_host.sv
// nvc_host: host controller issuing sram cycles and nonvolatile commands
// Functional notes
// - host issues six reads; first three at fixed addresses in order
// - reads four and five at fixed addresses; return ordinary data
// - write strobe stays high for all six cycles
// - host holds store request low at least 15 ns
`timescale 1ns/100ps
`default_nettype none
module nvc_host #(
  parameter int RESTORE_CYC  = nvc_pkg::RESTORE_CYC,
  parameter int CMD_PROC_CYC = nvc_pkg::CMD_PROC_CYC,
  parameter int HW_DIS_CYC   = nvc_pkg::HW_DIS_CYC
) (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic        req_write,
  input  wire logic [14:0] req_addr,
  input  wire logic [7:0]  req_wdata,
  output logic             rsp_valid,
  output logic [7:0]       rsp_rdata,
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire logic [1:0]  cmd_op,
  input  wire logic        save_req,
  output logic             op_busy,
  output logic             power_loss_save_on,
  output logic             sel_n,
  output logic             wr_n,
  output logic             oe_n,
  output logic [14:0]      addr,
  output logic [7:0]       dq_o,
  output logic             dq_oe,
  input  wire logic [7:0]  dq_i,
  output logic             store_request_busy_n_o,
  output logic             store_request_busy_n_oe,
  input  wire logic        store_request_busy_n_i
);
  // ****************************************************************
  // state
  // ****************************************************************
  typedef enum logic [5:0] {
    NVC_IDLE = 6'b000001,
    NVC_CYC  = 6'b000010,
    NVC_SEQ  = 6'b000100,
    NVC_WAIT = 6'b001000,
    NVC_HWRQ = 6'b010000,
    NVC_BUSY = 6'b100000
  } nvc_state_t;
  nvc_state_t  state;
  nvc_state_t  next_state;
  logic [2:0]  step;
  logic [1:0]  op;
  logic [17:0] tmr;
  logic        hs1;
  logic        hs2;
  logic        cyc_wr;
  nvc_bus_if   bus ();
  nvc_cycle u_cyc (
    .mclk  (mclk),
    .reset (reset),
    .bus   (bus),
    .sel_n (sel_n),
    .wr_n  (wr_n),
    .oe_n  (oe_n),
    .addr  (addr),
    .dq_o  (dq_o),
    .dq_oe (dq_oe),
    .dq_i  (dq_i)
  );
  // busy pin is sampled through two flops before use
  always_ff @(posedge mclk) begin
    hs1 <= store_request_busy_n_i;
    hs2 <= hs1;
  end
  // ****************************************************************
  // decode
  // ****************************************************************
  logic [14:0] seq_addr;
  logic [14:0] cmd_addr;
  always_comb begin
    case (step)
      3'h0: seq_addr = nvc_pkg::SEQ_A1;
      3'h1: seq_addr = nvc_pkg::SEQ_A2;
      3'h2: seq_addr = nvc_pkg::SEQ_A3;
      3'h3: seq_addr = nvc_pkg::SEQ_A4;
      3'h4: seq_addr = nvc_pkg::SEQ_A5;
      default: seq_addr = cmd_addr;
    endcase
  end
  always_comb begin
    case (op)
      nvc_pkg::OP_SAVE:     cmd_addr = nvc_pkg::CMD_SAVE;
      nvc_pkg::OP_RESTORE:  cmd_addr = nvc_pkg::CMD_RESTORE;
      nvc_pkg::OP_SAVE_OFF: cmd_addr = nvc_pkg::CMD_SAVE_OFF;
      default:              cmd_addr = nvc_pkg::CMD_SAVE_ON;
    endcase
  end
  wire is_idle   = (state == NVC_IDLE);
  wire long_op   = (op == nvc_pkg::OP_SAVE) || (op == nvc_pkg::OP_RESTORE);
  wire tmr_done  = (tmr == 18'h00000);
  wire last_step = (step == 3'h5);
  assign req_ready = is_idle && !save_req && bus.idle;
  assign cmd_ready = is_idle && !save_req && !req_valid && bus.idle;
  assign op_busy   = !is_idle;
  // done and idle overlap for one cycle; starting then would repeat a read
  assign bus.start = (state == NVC_CYC || state == NVC_SEQ) && bus.idle
                     && !bus.done;
  assign bus.write = (state == NVC_CYC) ? req_write : 1'b0;
  assign bus.addr  = (state == NVC_SEQ) ? seq_addr : req_addr;
  assign bus.wdata = req_wdata;
  assign store_request_busy_n_o = 1'b0;
  // ****************************************************************
  // sequencer
  // ****************************************************************
  always_comb begin
    next_state = state;
    case (state)
      NVC_IDLE: begin
        if (save_req)
          next_state = NVC_HWRQ;
        else if (req_valid)
          next_state = NVC_CYC;
        else if (cmd_valid)
          next_state = NVC_SEQ;
      end
      NVC_CYC:  if (bus.done) next_state = NVC_IDLE;
      NVC_SEQ:  if (bus.done && last_step) next_state = NVC_WAIT;
      NVC_WAIT: if (tmr_done) next_state = NVC_IDLE;
      NVC_HWRQ: if (tmr_done) next_state = NVC_BUSY;
      NVC_BUSY: if (hs2) next_state = NVC_IDLE;
      default:  next_state = NVC_IDLE;
    endcase
  end
  always_ff @(posedge mclk) begin
    if (reset) begin
      state <= NVC_IDLE; step <= 3'h0; op <= 2'h0; tmr <= 18'h00000;
      cyc_wr <= 1'b0; rsp_valid <= 1'b0; rsp_rdata <= 8'h00;
      store_request_busy_n_oe <= 1'b0;
      power_loss_save_on <= 1'b1;
    end else begin
      state <= next_state;
      rsp_valid <= (state == NVC_CYC) && bus.done && !cyc_wr;
      if (bus.done) rsp_rdata <= bus.rdata;
      if (!tmr_done) tmr <= tmr - 18'h1;
      case (state)
        NVC_IDLE: begin
          step <= 3'h0;
          op <= cmd_op;
          cyc_wr <= req_write;
          if (save_req) begin
            store_request_busy_n_oe <= 1'b1;
            tmr <= 18'(HW_DIS_CYC);
          end
        end
        NVC_SEQ: if (bus.done) begin
          step <= step + 3'h1;
          if (last_step) begin
            tmr <= long_op ? ((op == nvc_pkg::OP_RESTORE) ?
                   18'(RESTORE_CYC) : 18'(HW_DIS_CYC))
                 : 18'(CMD_PROC_CYC);
            if (op == nvc_pkg::OP_SAVE_OFF) power_loss_save_on <= 1'b0;
            if (op == nvc_pkg::OP_SAVE_ON) power_loss_save_on <= 1'b1;
          end
        end
        NVC_HWRQ: if (tmr_done) store_request_busy_n_oe <= 1'b0;
        default: ;
      endcase
    end
  end
  // ****************************************************************
  // checks
  // ****************************************************************
  AST_SEQ_NO_WRITE: assert property (
    @(posedge mclk) disable iff (reset)
    (state == NVC_SEQ) |-> wr_n) else $error("write during sequence");
  AST_SEQ_FIRST: assert property (
    @(posedge mclk) disable iff (reset)
    (state == NVC_SEQ && bus.start && step == 3'h0)
      |=> (addr == nvc_pkg::SEQ_A1)) else $error("bad first addr");
  AST_SEQ_FOURTH: assert property (
    @(posedge mclk) disable iff (reset)
    (state == NVC_SEQ && bus.start && step == 3'h3)
      |=> (addr == nvc_pkg::SEQ_A4)) else $error("bad fourth addr");
  AST_SAVE_ADDR: assert property (
    @(posedge mclk) disable iff (reset)
    (state == NVC_SEQ && bus.start && last_step && op == nvc_pkg::OP_SAVE)
      |=> (addr == nvc_pkg::CMD_SAVE)) else $error("bad save addr");
  AST_SEL_GAP: assert property (
    @(posedge mclk) disable iff (reset)
    $rose(sel_n) |=> sel_n) else $error("cycle restarted at once");
  AST_HW_HOLD: assert property (
    @(posedge mclk) disable iff (reset)
    $rose(store_request_busy_n_oe) |-> store_request_busy_n_oe [*2])
    else $error("save request too short");
  AST_LOCKOUT: assert property (
    @(posedge mclk) disable iff (reset)
    (state == NVC_WAIT) |-> sel_n) else $error("access in lockout");
  AST_IDLE_PINS: assert property (
    @(posedge mclk) disable iff (reset)
    is_idle |-> (sel_n && !dq_oe)) else $error("pins active when idle");
  AST_READ_GATE: assert property (
    @(posedge mclk) disable iff (reset)
    (!sel_n && wr_n) |-> (!oe_n && !dq_oe)) else $error("read without gate");
  AST_WRITE_DRIVE: assert property (
    @(posedge mclk) disable iff (reset)
    !wr_n |-> (!sel_n && dq_oe)) else $error("write without data");
  AST_DEFAULT_ON: assert property (
    @(posedge mclk)
    $fell(reset) |-> power_loss_save_on) else $error("default off");
endmodule
`default_nettype wire

//--- verif/nvc_nvram_model.sv
// nvc_nvram_model: behavioural nonvolatile sram seen from its pins
`timescale 1ns/100ps
`default_nettype none
module nvc_nvram_model #(
  parameter int DIS_NS  = 1000,
  parameter int SAVE_NS = 300,
  parameter int RCL_NS  = 300
) (
  input  wire logic        sel_n,
  input  wire logic        wr_n,
  input  wire logic        oe_n,
  input  wire logic [14:0] addr,
  input  wire logic [7:0]  dq,
  output logic [7:0]       q,
  output logic             q_oe,
  input  wire logic        store_request_busy_n,
  output logic             busy
);
  logic [7:0]  mem [0:32767];
  logic [7:0]  nv  [0:32767];
  logic [13:0] seq [0:4];
  logic [7:0]  last;
  logic [2:0]  step;
  logic        dirty;
  logic        auto_on;
  int          saves;
  int          restores;
  // ****************************************************************
  // array and pins
  // ****************************************************************
  initial begin
    seq = '{14'h0E38, 14'h31C7, 14'h03E0, 14'h3C1F, 14'h303F};
    step = 3'h0;
    dirty = 1'b0;
    auto_on = 1'b1;
    saves = 0;
    restores = 0;
    busy = 1'b0;
    last = 8'h00;
  end
  assign q_oe = !sel_n && wr_n && !oe_n && !busy;
  // a floated bus shows the inverse of the last byte, never a stale copy
  assign q = q_oe ? mem[addr] : ~last;
  always @(q_oe or addr) if (q_oe) last = mem[addr];
  always @* begin
    if (!sel_n && !wr_n && !busy) begin
      mem[addr] = dq;
      dirty = 1'b1;
    end
  end
  task automatic do_save;
    int i;
    busy = 1'b1;
    #SAVE_NS;
    for (i = 0; i < 32768; i++) nv[i] = mem[i];
    saves++;
    dirty = 1'b0;
    busy = 1'b0;
  endtask
  // ****************************************************************
  // command recognizer
  // ****************************************************************
  always @(negedge sel_n) begin
    // let pins launched on the same edge settle before sampling
    #1;
    if (busy || !wr_n) step = 3'h0;
    else if (step == 3'h5) begin
      step = 3'h0;
      case (addr[13:0])
        14'h0FC0: do_save;
        14'h0C63: begin
          busy = 1'b1;
          #RCL_NS;
          foreach (nv[i]) mem[i] = nv[i];
          restores++;
          dirty = 1'b0;
          busy = 1'b0;
        end
        14'h03F8: auto_on = 1'b0;
        14'h07F0: auto_on = 1'b1;
        default: ;
      endcase
    end
    else if (addr[13:0] == seq[step]) step = step + 3'h1;
    else step = (addr[13:0] == seq[0]) ? 3'h1 : 3'h0;
  end
  always @(negedge store_request_busy_n) begin
    if (!busy) begin
      #DIS_NS;
      if (dirty && !busy) do_save;
    end
  end
endmodule
`default_nettype wire

//--- verif/nvc_host_test.sv
// nvc_host_test: self-checking bench for the host controller
`timescale 1ns/100ps
`default_nettype none
module nvc_host_test;
  logic        mclk, reset, req_valid, req_ready, req_write, rsp_valid;
  logic        cmd_valid, cmd_ready, save_req, op_busy, plss_on;
  logic        sel_n, wr_n, oe_n, dq_oe, srb_n_o, srb_n_oe, srb_n;
  logic        m_oe, m_busy;
  logic [14:0] req_addr, addr;
  logic [7:0]  req_wdata, rsp_rdata, dq_o, dq_i, m_q, q;
  logic [1:0]  cmd_op;
  int          failures, checks_done, s, r;
  // ****************************************************************
  // design, device model and shared pins
  // ****************************************************************
  assign srb_n = !((srb_n_oe && !srb_n_o) || m_busy);
  assign dq_i = dq_oe ? dq_o : m_q;
  nvc_host #(.RESTORE_CYC(20), .CMD_PROC_CYC(20), .HW_DIS_CYC(60)) DUT (
    .mclk(mclk), .reset(reset), .req_valid(req_valid),
    .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
    .save_req(save_req), .op_busy(op_busy), .power_loss_save_on(plss_on),
    .sel_n(sel_n), .wr_n(wr_n), .oe_n(oe_n), .addr(addr), .dq_o(dq_o),
    .dq_oe(dq_oe), .dq_i(dq_i), .store_request_busy_n_o(srb_n_o),
    .store_request_busy_n_oe(srb_n_oe), .store_request_busy_n_i(srb_n));
  nvc_nvram_model model (.sel_n(sel_n), .wr_n(wr_n), .oe_n(oe_n),
    .addr(addr), .dq(dq_i), .q(m_q), .q_oe(m_oe),
    .store_request_busy_n(srb_n), .busy(m_busy));
  always #12.5 mclk = ~mclk;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    while (op_busy !== 1'b0 && n < 5000) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 5000) failures++;
  endtask
  task automatic access(input logic w, input logic [14:0] a,
                        input logic [7:0] d, output logic [7:0] rd);
    int n;
    n = 0;
    {req_valid, req_write, req_addr, req_wdata} = {1'b1, w, a, d};
    while (req_ready !== 1'b1 && n < 100) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 100) failures++;
    @(negedge mclk);
    req_valid = 1'b0;
    while (!w && rsp_valid !== 1'b1 && n < 200) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 200) failures++;
    rd = rsp_rdata;
    wait_idle;
  endtask
  task automatic do_cmd(input logic [1:0] op);
    cmd_valid = 1'b1;
    cmd_op = op;
    while (cmd_ready !== 1'b1) @(negedge mclk);
    @(negedge mclk);
    cmd_valid = 1'b0;
    wait_idle;
  endtask
  task automatic pin_save;
    save_req = 1'b1;
    repeat (4) @(negedge mclk);
    save_req = 1'b0;
    wait_idle;
  endtask
  task conclude;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task t_rw;
    access(1'b1, 15'h1234, 8'hA5, q);
    access(1'b1, 15'h5234, 8'h3C, q);
    access(1'b0, 15'h1234, 8'h00, q);
    check(q, 8'hA5);
    access(1'b0, 15'h5234, 8'h00, q);
    check(q, 8'h3C);
    $display("t_rw done");
  endtask
  task t_cmds;
    for (int op = 0; op < 4; op++) begin
      s = model.saves;
      r = model.restores;
      do_cmd(2'(op));
      check({7'h00, plss_on}, {7'h00, op != 2});
      check({7'h00, model.auto_on}, {7'h00, op != 2});
      check(8'(model.saves - s), {7'h00, op == 0});
      check(8'(model.restores - r), {7'h00, op == 1});
    end
    $display("t_cmds done");
  endtask
  task t_save_restore;
    access(1'b1, 15'h0100, 8'h5A, q);
    do_cmd(2'h0);
    check(model.nv[15'h0100], 8'h5A);
    access(1'b1, 15'h0100, 8'hC3, q);
    do_cmd(2'h1);
    access(1'b0, 15'h0100, 8'h00, q);
    check(q, 8'h5A);
    $display("t_save_restore done");
  endtask
  task t_pin;
    access(1'b1, 15'h0200, 8'h77, q);
    s = model.saves;
    pin_save;
    check(8'(model.saves - s), 8'h01);
    check(model.nv[15'h0200], 8'h77);
    pin_save;
    check(8'(model.saves - s), 8'h01);
    access(1'b0, 15'h0200, 8'h00, q);
    check(q, 8'h77);
    $display("t_pin done");
  endtask
  initial begin
    {mclk, reset, req_valid, req_write, cmd_valid, save_req} = 6'h10;
    {req_addr, req_wdata, cmd_op} = 25'h0000000;
    failures = 0;
    checks_done = 0;
    repeat (12) @(negedge mclk);
    reset = 1'b0;
    @(negedge mclk);
    check({7'h00, plss_on}, 8'h01);
    check({4'h0, sel_n, wr_n, oe_n, dq_oe}, 8'h0E);
    t_rw;
    t_cmds;
    t_save_restore;
    t_pin;
    conclude;
  end
  // the whole run needs a few hundred cycles
  initial begin
    repeat (40000) @(posedge mclk);
    failures++;
    conclude;
  end
endmodule
`default_nettype wire
